/* card_status_pkg.sv */
`default_nettype none
package card_status_pkg;
	localparam int unsigned bit_ecc_fail      = 21;
	localparam int unsigned bit_ctrl_fault    = 20;
	localparam int unsigned bit_gen_fail      = 19;
	localparam int unsigned bit_underrun      = 18;
	localparam int unsigned bit_overrun       = 17;
	localparam int unsigned bit_overwrite     = 16;
	localparam int unsigned bit_wp_erase_skip = 15;
	localparam int unsigned bit_reserved_hi   = 14;
	localparam int unsigned bit_erase_reset   = 13;
	localparam int unsigned bit_state_hi      = 12;
	localparam int unsigned bit_state_lo      = 9;
	localparam int unsigned bit_ready         = 8;
	localparam int unsigned bit_switch_fail   = 7;
	localparam int unsigned bit_reserved_lo   = 6;

	localparam logic [31:0] status_reset = 32'h0000_0000;
	localparam logic [5:0]  index_reset  = 6'h00;
	localparam logic [3:0]  state_reset  = 4'h0;

	localparam logic [5:0] cmd_erase_start = 6'h23;
	localparam logic [5:0] cmd_erase_end   = 6'h24;
	localparam logic [5:0] cmd_erase_run   = 6'h26;
	localparam logic [5:0] cmd_get_status  = 6'h0d;

	typedef enum logic [3:0]
	{
		cs_idle     = 4'h0,
		cs_ready    = 4'h1,
		cs_ident    = 4'h2,
		cs_standby  = 4'h3,
		cs_transfer = 4'h4,
		cs_send     = 4'h5,
		cs_receive  = 4'h6,
		cs_program  = 4'h7,
		cs_disconn  = 4'h8,
		cs_bus_test = 4'h9,
		cs_sleep    = 4'ha
	} card_state_t;

	typedef enum logic [2:0]
	{
		ers_idle  = 3'b001,
		ers_start = 3'b010,
		ers_end   = 3'b100
	} erase_seq_t;

	typedef struct packed
	{
		logic ecc_fail;
		logic ctrl_fault;
		logic gen_fail;
		logic underrun;
		logic overrun;
		logic id_rewrite;
		logic cfg_ro_mismatch;
		logic protect_revert;
		logic wp_erase_skip;
		logic switch_fail;
	} err_events_t;

	typedef struct packed
	{
		logic       reject;
		logic [5:0] index;
	} cmd_info_t;
endpackage
`default_nettype wire

/* bit_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_sync
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic meta;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= 1'b0;
			q    <= 1'b0;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire

/* card_status_low_half_bits.sv */
`timescale 1ns/1ps
`default_nettype none
module card_status_low_half_bits
(
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire card_status_pkg::err_events_t err_events,
	input  wire logic [3:0]                  card_state,
	input  wire logic                        buffer_empty,
	output logic                             exec_valid,
	output logic [5:0]                       exec_index,
	output logic                             erase_abort,
	output logic                             op_abort,
	input  wire logic                        link_clk,
	input  wire logic                        cmd_valid,
	input  wire logic [5:0]                  cmd_index,
	input  wire logic                        cmd_reject,
	output logic                             resp_valid,
	output logic [31:0]                      resp_status
);
	// link side: command capture
	logic                        req_tog;
	card_status_pkg::cmd_info_t  cmd_hold;
	logic                        ack_s;
	logic                        ack_seen;
	logic                        ack_edge;

	// core side
	logic                        req_s;
	logic                        req_seen;
	logic                        req_new;
	logic                        ack_tog;
	logic [31:0]                 snapshot;
	logic                        ecc_fail;
	logic                        ctrl_fault;
	logic                        gen_fail;
	logic                        underrun;
	logic                        overrun;
	logic                        overwrite;
	logic                        overwrite_event;
	logic                        wp_erase_skip;
	logic                        switch_fail;
	logic                        exec_event;
	logic                        erase_hit;
	card_status_pkg::erase_seq_t erase_seq;
	card_status_pkg::erase_seq_t next_erase_seq;
	logic [31:0]                 next_snapshot;

	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
			req_tog <= 1'b0;
		else if (cmd_valid)
			req_tog <= ~req_tog;
	end

	// index and reject flag stay put until the next command arrives
	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
			cmd_hold <= '0;
		else if (cmd_valid)
		begin
			cmd_hold.index  <= cmd_index;
			cmd_hold.reject <= cmd_reject;
		end
	end

	bit_sync u_req_sync
	(
		.clk   (mclk),
		.rst_n (rst_n),
		.d     (req_tog),
		.q     (req_s)
	);

	bit_sync u_ack_sync
	(
		.clk   (link_clk),
		.rst_n (rst_n),
		.d     (ack_tog),
		.q     (ack_s)
	);

	assign req_new = req_s ^ req_seen;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			req_seen <= 1'b0;
		else
			req_seen <= req_s;
	end

	// the three configuration faults share one flag
	assign overwrite_event = err_events.id_rewrite
		| err_events.cfg_ro_mismatch
		| err_events.protect_revert;

	// sticky error flags: a new event wins over the clear of a reported flag
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ecc_fail <= 1'b0;
		else
			ecc_fail <= (ecc_fail & ~req_new) | err_events.ecc_fail;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_fault <= 1'b0;
		else
			ctrl_fault <= (ctrl_fault & ~req_new) | err_events.ctrl_fault;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			gen_fail <= 1'b0;
		else
			gen_fail <= (gen_fail & ~req_new) | err_events.gen_fail;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			underrun <= 1'b0;
		else
			underrun <= (underrun & ~req_new) | err_events.underrun;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			overrun <= 1'b0;
		else
			overrun <= (overrun & ~req_new) | err_events.overrun;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			overwrite <= 1'b0;
		else
			overwrite <= (overwrite & ~req_new) | overwrite_event;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			wp_erase_skip <= 1'b0;
		else
			wp_erase_skip <= (wp_erase_skip & ~req_new) | err_events.wp_erase_skip;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			switch_fail <= 1'b0;
		else
			switch_fail <= (switch_fail & ~req_new) | err_events.switch_fail;
	end

	// execution errors halt the running operation; a controller fault does not
	assign exec_event = err_events.ecc_fail
		| err_events.gen_fail
		| err_events.underrun
		| err_events.overrun
		| overwrite_event
		| err_events.wp_erase_skip
		| err_events.switch_fail;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			op_abort <= 1'b0;
		else
			op_abort <= exec_event;
	end

	// erase sequence tracking
	always_comb
	begin
		next_erase_seq = erase_seq;
		erase_hit      = 1'b0;
		if (req_new && !cmd_hold.reject)
		begin
			case (cmd_hold.index)
				card_status_pkg::cmd_erase_start:
					next_erase_seq = card_status_pkg::ers_start;
				card_status_pkg::cmd_erase_end:
					next_erase_seq = card_status_pkg::ers_end;
				card_status_pkg::cmd_erase_run:
					next_erase_seq = card_status_pkg::ers_idle;
				card_status_pkg::cmd_get_status:
					next_erase_seq = erase_seq;
				default:
				begin
					if (erase_seq != card_status_pkg::ers_idle)
					begin
						next_erase_seq = card_status_pkg::ers_idle;
						erase_hit      = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			erase_seq <= card_status_pkg::ers_idle;
		else
			erase_seq <= next_erase_seq;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			erase_abort <= 1'b0;
		else
			erase_abort <= erase_hit;
	end

	// response word taken at command arrival
	always_comb
	begin
		next_snapshot                                                   = '0;
		next_snapshot[card_status_pkg::bit_ecc_fail]                    = ecc_fail;
		next_snapshot[card_status_pkg::bit_ctrl_fault]                  = ctrl_fault;
		next_snapshot[card_status_pkg::bit_gen_fail]                    = gen_fail;
		next_snapshot[card_status_pkg::bit_underrun]                    = underrun;
		next_snapshot[card_status_pkg::bit_overrun]                     = overrun;
		next_snapshot[card_status_pkg::bit_overwrite]                   = overwrite;
		next_snapshot[card_status_pkg::bit_wp_erase_skip]               = wp_erase_skip;
		next_snapshot[card_status_pkg::bit_reserved_hi]                 = 1'b0;
		next_snapshot[card_status_pkg::bit_erase_reset]                 = erase_hit;
		next_snapshot[card_status_pkg::bit_state_hi:card_status_pkg::bit_state_lo]
			= card_state;
		next_snapshot[card_status_pkg::bit_ready]                       = buffer_empty;
		next_snapshot[card_status_pkg::bit_switch_fail]                 = switch_fail;
		next_snapshot[card_status_pkg::bit_reserved_lo]                 = 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			snapshot <= card_status_pkg::status_reset;
		else if (req_new)
			snapshot <= next_snapshot;
	end

	// tell the link side that the word is ready; it stays put until the next command
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ack_tog <= 1'b0;
		else if (req_new)
			ack_tog <= ~ack_tog;
	end

	// hand the command on only after its state was captured
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			exec_valid <= 1'b0;
		else
			exec_valid <= req_new & ~cmd_hold.reject;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			exec_index <= card_status_pkg::index_reset;
		else if (req_new)
			exec_index <= cmd_hold.index;
	end

	// link side: response delivery
	assign ack_edge = ack_s ^ ack_seen;

	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
			ack_seen <= 1'b0;
		else
			ack_seen <= ack_s;
	end

	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
			resp_valid <= 1'b0;
		else
			resp_valid <= ack_edge;
	end

	always_ff @(posedge link_clk or negedge rst_n)
	begin
		if (!rst_n)
			resp_status <= card_status_pkg::status_reset;
		else if (ack_edge)
			resp_status <= snapshot;
	end
endmodule
`default_nettype wire

/* card_status_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module card_status_checker
(
	input wire logic                         mclk,
	input wire logic                         rst_n,
	input wire card_status_pkg::err_events_t err_events,
	input wire logic [3:0]                   card_state,
	input wire logic                         buffer_empty,
	input wire logic                         exec_valid,
	input wire logic [5:0]                   exec_index,
	input wire logic                         erase_abort,
	input wire logic                         op_abort,
	input wire logic                         link_clk,
	input wire logic                         cmd_valid,
	input wire logic [5:0]                   cmd_index,
	input wire logic                         cmd_reject,
	input wire logic                         resp_valid,
	input wire logic [31:0]                  resp_status
);
	AST_UNUSED_ZERO: assert property (@(posedge link_clk) disable iff (!rst_n)
		(resp_status & 32'hffc0_407f) == 32'h0) else $error("unused status bits set");
	AST_STATE_CODE: assert property (@(posedge link_clk) disable iff (!rst_n)
		resp_valid |-> resp_status[12:9] <= 4'ha) else $error("state code out of range");
	AST_RESP_TIME: assert property (@(posedge link_clk) disable iff (!rst_n)
		cmd_valid |-> ##[2:6] resp_valid) else $error("no response in time");
	AST_RESP_HOLD: assert property (@(posedge link_clk) disable iff (!rst_n)
		!resp_valid |-> $stable(resp_status)) else $error("status moved without response");
	AST_OP_ABORT: assert property (@(posedge mclk) disable iff (!rst_n)
		(|(err_events & 10'h2ff)) |=> op_abort) else $error("execution error did not stop");
	AST_CTRL_ONLY: assert property (@(posedge mclk) disable iff (!rst_n)
		err_events == 10'h100 |=> !op_abort) else $error("controller fault stopped op");
	AST_EXEC_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
		exec_valid |=> !exec_valid) else $error("exec pulse too long");
	AST_ERASE_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
		erase_abort |=> !erase_abort) else $error("erase abort pulse too long");
endmodule
bind card_status_low_half_bits card_status_checker chk (.*);
`default_nettype wire

/* host_cmd_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model
(
	output logic       link_clk,
	output logic       cmd_valid,
	output logic [5:0] cmd_index,
	output logic       cmd_reject,
	input  wire logic  resp_valid
);
	initial
	begin
		link_clk = 1'b0;
		#37;
		forever #62.5 link_clk = ~link_clk;
	end
	initial
	begin
		cmd_valid = 1'b0;
		cmd_index = 6'h00;
		cmd_reject = 1'b0;
	end
	task automatic send(input logic [5:0] idx, input logic rej);
		int n;
		@(posedge link_clk);
		cmd_valid <= 1'b1;
		cmd_index <= idx;
		cmd_reject <= rej;
		@(posedge link_clk);
		cmd_valid <= 1'b0;
		cmd_index <= ~idx;
		cmd_reject <= ~rej;
		for (n = 0; n < 10 && resp_valid !== 1'b1; n++)
			@(negedge link_clk);
	endtask
endmodule
`default_nettype wire

/* card_status_low_half_bits_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module card_status_low_half_bits_bench;
	logic                         mclk, rst_n, buffer_empty, exec_valid, erase_abort, op_abort;
	logic                         link_clk, cmd_valid, cmd_reject, resp_valid;
	card_status_pkg::err_events_t err_events;
	logic [3:0]                   card_state;
	logic [5:0]                   cmd_index;
	logic [31:0]                  resp_status;
	logic [31:0]                  expq[$];
	logic [5:0]                   exec_index;
	logic [5:0]                   idxq[$];
	int                           miscompares, num_checks, nexec, execs, ops, aborts;
	int                           map[10] = '{7, 15, 16, 16, 16, 17, 18, 19, 20, 21};
	card_status_low_half_bits DUT (.mclk(mclk), .rst_n(rst_n), .err_events(err_events),
		.card_state(card_state), .buffer_empty(buffer_empty), .exec_valid(exec_valid),
		.exec_index(exec_index), .erase_abort(erase_abort), .op_abort(op_abort),
		.link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
		.cmd_reject(cmd_reject), .resp_valid(resp_valid), .resp_status(resp_status));
	host_cmd_model host (.link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
		.cmd_reject(cmd_reject), .resp_valid(resp_valid));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report;
		if (miscompares == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cmd(input logic [5:0] idx, input logic rej, input logic [31:0] flags);
		@(negedge mclk);
		card_state = 4'($urandom % 11);
		buffer_empty = 1'($urandom);
		expq.push_back(flags | (32'({card_state, buffer_empty}) << 8));
		if (!rej)
		begin
			nexec++;
			idxq.push_back(idx);
		end
		host.send(idx, rej);
	endtask
	always @(negedge link_clk)
		if (resp_valid === 1'b1)
			check("resp_status", resp_status, expq.pop_front());
	always @(negedge mclk)
	begin
		execs += (exec_valid === 1'b1);
		ops += (op_abort === 1'b1);
		aborts += (erase_abort === 1'b1);
		if (exec_valid === 1'b1)
			check("exec_index", exec_index, idxq.pop_front());
	end
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial
	begin
		#100000;
		miscompares++;
		final_report();
	end
	initial
	begin
		rst_n = 1'b0;
		err_events = '0;
		card_state = 4'h0;
		buffer_empty = 1'b0;
		void'($urandom(92));
		repeat (20) @(negedge mclk);
		repeat (2) @(posedge link_clk);
		@(negedge mclk);
		rst_n = 1'b1;
		repeat (3) @(posedge link_clk);
		for (int i = 0; i < 10; i++)
		begin
			@(negedge mclk);
			err_events = 10'(1 << i);
			@(negedge mclk);
			err_events = '0;
			cmd(6'h0d, 1'b0, 32'h1 << map[i]);
			cmd(6'h0d, 1'b0, 32'h0);
		end
		@(negedge mclk);
		err_events = 10'h100;
		cmd(6'h0d, 1'b0, 32'h0010_0000);
		cmd(6'h0d, 1'b0, 32'h0010_0000);
		@(negedge mclk);
		err_events = '0;
		cmd(6'h0d, 1'b0, 32'h0010_0000);
		cmd(6'h0d, 1'b0, 32'h0);
		cmd(6'h23, 1'b0, 32'h0);
		cmd(6'h05, 1'b0, 32'h2000);
		cmd(6'h23, 1'b0, 32'h0);
		cmd(6'h24, 1'b0, 32'h0);
		cmd(6'h0d, 1'b0, 32'h0);
		cmd(6'h26, 1'b0, 32'h0);
		cmd(6'h23, 1'b0, 32'h0);
		cmd(6'h05, 1'b1, 32'h0);
		cmd(6'h26, 1'b0, 32'h0);
		repeat (4) @(posedge link_clk);
		check("exec_count", execs, nexec);
		check("op_abort_count", ops, 9);
		check("erase_abort_count", aborts, 1);
		check("pending", expq.size(), 0);
		check("exec_pending", idxq.size(), 0);
		final_report();
	end
endmodule
`default_nettype wire
